/* inc/hppi_defs.vh */
// constants for the hub port power and indicator pin block
`ifndef HPPI_DEFS_VH
`define HPPI_DEFS_VH

`define HPPI_NUM_PORTS 4

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define HPPI_ADDR_CTRL 12'h000
`define HPPI_ADDR_POLARITY 12'h004
`define HPPI_ADDR_STATUS 12'h008
`define HPPI_ADDR_MASK 12'h00C
`define HPPI_ADDR_STATE 12'h010
`define HPPI_ADDR_ENABLE 12'h014

// ---------------------------------------------------------------
// control fields
// ---------------------------------------------------------------
`define HPPI_CTRL_POWER_LSB 0
`define HPPI_CTRL_AMBER_LSB 4
`define HPPI_CTRL_GREEN_LSB 8
`define HPPI_CTRL_RESET 12'h000

// ---------------------------------------------------------------
// polarity fields: a set bit means the pin idles high (active low)
// ---------------------------------------------------------------
`define HPPI_POL_INDICATOR 0
`define HPPI_POL_OVERCURRENT 1
`define HPPI_POL_POWER 2
`define HPPI_POL_RESET 3'h7

// ---------------------------------------------------------------
// state fields and reset values
// ---------------------------------------------------------------
`define HPPI_STATE_OC_LSB 0
`define HPPI_STATE_POWER_LSB 4
`define HPPI_STATE_CFG_DONE 8
`define HPPI_STATUS_RESET 4'h0
`define HPPI_MASK_RESET 4'h0
`define HPPI_ENABLE_RESET 4'hF

`endif

/* rtl/hppi_port.v */
// one downstream port: indicator, power switch and overcurrent pins
`timescale 1ns/100ps
`default_nettype none

module hppi_port (
    input wire clk_in,
    input wire rst_in,
    input wire power_req_in,
    input wire amber_req_in,
    input wire green_req_in,
    input wire pol_indicator_in,
    input wire pol_overcurrent_in,
    input wire pol_power_in,
    input wire drive_en_in,
    input wire overcurrent_pin_in,
    output reg amber_pin_out,
    output reg green_pin_out,
    output reg power_pin_out,
    output reg power_oe_out,
    output wire overcurrent_out,
    output wire overcurrent_event_out
);

    reg ovr_sample;
    reg ovr_prev;

    // ---------------------------------------------------------------
    // overcurrent sampling
    // ---------------------------------------------------------------
    // pin is synchronous, one register is enough
    assign overcurrent_out = ovr_sample ^ pol_overcurrent_in;
    assign overcurrent_event_out = overcurrent_out & ~ovr_prev;

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ovr_sample <= 1'b1;
            ovr_prev <= 1'b0;
        end else begin
            ovr_sample <= overcurrent_pin_in;
            ovr_prev <= overcurrent_out;
        end
    end

    // ---------------------------------------------------------------
    // output pins: request xor idle level, registered
    // ---------------------------------------------------------------
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            amber_pin_out <= 1'b1;
            green_pin_out <= 1'b1;
            power_pin_out <= 1'b1;
            power_oe_out <= 1'b0;
        end else begin
            amber_pin_out <= amber_req_in ^ pol_indicator_in;
            green_pin_out <= green_req_in ^ pol_indicator_in;
            power_pin_out <= power_req_in ^ pol_power_in;
            power_oe_out <= drive_en_in;
        end
    end

endmodule

`default_nettype wire

/* rtl/hppi_top.v */
// hub downstream port power, overcurrent and indicator pin logic
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "hppi_defs.vh"

module hppi_top (
    input wire SYS_CLK_IN,
    input wire RST_IN,
    input wire PSEL_IN,
    input wire PENABLE_IN,
    input wire PWRITE_IN,
    input wire [11:0] PADDR_IN,
    input wire [31:0] PWDATA_IN,
    output reg [31:0] PRDATA_OUT,
    output wire PREADY_OUT,
    output wire PSLVERR_OUT,
    output wire IRQ_OUT,
    input wire CFG_LOAD_IN,
    input wire [2:0] CFG_POLARITY_IN,
    input wire CFG_DONE_IN,
    input wire [3:0] PORT_OVERCURRENT_N_IN,
    output wire [3:0] PORT_AMBER_N_OUT,
    output wire [3:0] PORT_GREEN_N_OUT,
    output wire [3:0] PORT_POWER_ENABLE_N_OUT,
    output wire [3:0] PORT_POWER_ENABLE_N_OE_OUT
);

    reg [3:0] power_req;
    reg [3:0] amber_req;
    reg [3:0] green_req;
    reg [3:0] port_enable;
    reg [2:0] pol_staged;
    reg [2:0] pol_active;
    reg cfg_done;
    reg [3:0] status;
    reg [3:0] mask;
    reg [31:0] next_prdata;
    reg addr_ok;

    wire [3:0] oc_live;
    wire [3:0] oc_event;
    wire [3:0] power_drive;
    wire access;
    wire wr;
    wire rd;
    wire status_read;

    // ---------------------------------------------------------------
    // apb handshake
    // ---------------------------------------------------------------
    // zero wait states: every access ends in its first access cycle
    assign access = PSEL_IN & PENABLE_IN;
    assign wr = access & PWRITE_IN;
    // read setup cycle: data is latched and status cleared here
    assign rd = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = access & ~addr_ok;
    // clear where the data is latched, so an event landing between
    // capture and access is not lost
    assign status_read = rd & (PADDR_IN == `HPPI_ADDR_STATUS);

    always @* begin
        if (PADDR_IN == `HPPI_ADDR_CTRL) begin
            addr_ok = 1'b1;
        end else if (PADDR_IN == `HPPI_ADDR_POLARITY) begin
            addr_ok = 1'b1;
        end else if (PADDR_IN == `HPPI_ADDR_STATUS) begin
            addr_ok = 1'b1;
        end else if (PADDR_IN == `HPPI_ADDR_MASK) begin
            addr_ok = 1'b1;
        end else if (PADDR_IN == `HPPI_ADDR_STATE) begin
            addr_ok = 1'b1;
        end else if (PADDR_IN == `HPPI_ADDR_ENABLE) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // read data
    // ---------------------------------------------------------------
    always @* begin
        next_prdata = 32'h0000_0000;
        if (PADDR_IN == `HPPI_ADDR_CTRL) begin
            next_prdata[`HPPI_CTRL_POWER_LSB +: 4] = power_req;
            next_prdata[`HPPI_CTRL_AMBER_LSB +: 4] = amber_req;
            next_prdata[`HPPI_CTRL_GREEN_LSB +: 4] = green_req;
        end else if (PADDR_IN == `HPPI_ADDR_POLARITY) begin
            next_prdata[2:0] = pol_active;
        end else if (PADDR_IN == `HPPI_ADDR_STATUS) begin
            next_prdata[3:0] = status;
        end else if (PADDR_IN == `HPPI_ADDR_MASK) begin
            next_prdata[3:0] = mask;
        end else if (PADDR_IN == `HPPI_ADDR_STATE) begin
            next_prdata[`HPPI_STATE_OC_LSB +: 4] = oc_live;
            next_prdata[`HPPI_STATE_POWER_LSB +: 4] = power_drive;
            next_prdata[`HPPI_STATE_CFG_DONE] = cfg_done;
        end else if (PADDR_IN == `HPPI_ADDR_ENABLE) begin
            next_prdata[3:0] = port_enable;
        end else begin
            next_prdata = 32'h0000_0000;
        end
    end

    // read data is registered in the setup cycle so it stands in access
    always @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            PRDATA_OUT <= 32'h0000_0000;
        end else if (rd) begin
            PRDATA_OUT <= next_prdata;
        end
    end

    // ---------------------------------------------------------------
    // configuration load
    // ---------------------------------------------------------------
    // staged polarity is held back until the memory read is complete,
    // so pins never glitch through a half-loaded setting
    always @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pol_staged <= `HPPI_POL_RESET;
            pol_active <= `HPPI_POL_RESET;
            cfg_done <= 1'b0;
        end else begin
            if (CFG_LOAD_IN & ~cfg_done) begin
                pol_staged <= CFG_POLARITY_IN;
            end
            if (CFG_DONE_IN & ~cfg_done) begin
                cfg_done <= 1'b1;
                pol_active <= pol_staged;
            end
        end
    end

    // ---------------------------------------------------------------
    // control registers
    // ---------------------------------------------------------------
    always @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            power_req <= 4'h0;
            amber_req <= 4'h0;
            green_req <= 4'h0;
            mask <= `HPPI_MASK_RESET;
            port_enable <= `HPPI_ENABLE_RESET;
        end else begin
            if (wr & (PADDR_IN == `HPPI_ADDR_CTRL)) begin
                power_req <= PWDATA_IN[`HPPI_CTRL_POWER_LSB +: 4] & ~oc_event;
                amber_req <= PWDATA_IN[`HPPI_CTRL_AMBER_LSB +: 4];
                green_req <= PWDATA_IN[`HPPI_CTRL_GREEN_LSB +: 4];
            end else begin
                // overcurrent drops port power at once
                power_req <= power_req & ~oc_event;
            end
            if (wr & (PADDR_IN == `HPPI_ADDR_MASK)) begin
                mask <= PWDATA_IN[3:0];
            end
            if (wr & (PADDR_IN == `HPPI_ADDR_ENABLE)) begin
                port_enable <= PWDATA_IN[3:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // interrupt status
    // ---------------------------------------------------------------
    // a new event in the clearing read's cycle stays set
    always @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            status <= `HPPI_STATUS_RESET;
        end else if (status_read) begin
            status <= oc_event & port_enable;
        end else begin
            status <= status | (oc_event & port_enable);
        end
    end

    assign IRQ_OUT = |(status & mask);

    // ---------------------------------------------------------------
    // per-port pin logic
    // ---------------------------------------------------------------
    // power switch stays undriven until configuration is known;
    // disabled ports keep pins at idle and never raise events
    assign power_drive = port_enable & {4{cfg_done}};

    genvar gi;
    generate
        for (gi = 0; gi < `HPPI_NUM_PORTS; gi = gi + 1) begin : g_port
            hppi_port u_port (
                .clk_in(SYS_CLK_IN),
                .rst_in(RST_IN),
                .power_req_in(power_req[gi] & port_enable[gi]),
                .amber_req_in(amber_req[gi] & port_enable[gi]),
                .green_req_in(green_req[gi] & port_enable[gi]),
                .pol_indicator_in(pol_active[`HPPI_POL_INDICATOR]),
                .pol_overcurrent_in(pol_active[`HPPI_POL_OVERCURRENT]),
                .pol_power_in(pol_active[`HPPI_POL_POWER]),
                .drive_en_in(power_drive[gi]),
                .overcurrent_pin_in(PORT_OVERCURRENT_N_IN[gi]),
                .amber_pin_out(PORT_AMBER_N_OUT[gi]),
                .green_pin_out(PORT_GREEN_N_OUT[gi]),
                .power_pin_out(PORT_POWER_ENABLE_N_OUT[gi]),
                .power_oe_out(PORT_POWER_ENABLE_N_OE_OUT[gi]),
                .overcurrent_out(oc_live[gi]),
                .overcurrent_event_out(oc_event[gi])
            );
        end
    endgenerate

endmodule

`default_nettype wire

/* verification/hppi_board.sv */
// board model: overcurrent sensors and the power switch line
`timescale 1ns/100ps
`default_nettype none
module hppi_board (
    input wire logic clk_in,
    input wire logic idle_hi_in,
    input wire logic [1:0] fault_in,
    input wire logic [3:0] pwr_n_in,
    input wire logic [3:0] pwr_oe_in,
    output logic [3:0] oc_n_out,
    output logic [3:0] pwr_wire_out
);
    logic [3:0] last = 4'h0;
    // two-port board: ports 2 and 3 pulled to inactive, never floating
    assign oc_n_out = {{2{idle_hi_in}}, fault_in ^ {2{idle_hi_in}}};
    // undriven switch line shows a changing level, not its last value
    assign pwr_wire_out = (pwr_oe_in & pwr_n_in) | (~pwr_oe_in & ~last);
    always @(posedge clk_in) begin
        last <= pwr_wire_out;
    end
endmodule
`default_nettype wire

/* verification/hppi_chk.sv */
// assertions on the pin side of the port block
`timescale 1ns/100ps
`default_nettype none
module hppi_chk (
    input wire SYS_CLK_IN,
    input wire RST_IN,
    input wire CFG_LOAD_IN,
    input wire [2:0] CFG_POLARITY_IN,
    input wire CFG_DONE_IN,
    input wire IRQ_OUT,
    input wire [3:0] PORT_OVERCURRENT_N_IN,
    input wire [3:0] PORT_AMBER_N_OUT,
    input wire [3:0] PORT_GREEN_N_OUT,
    input wire [3:0] PORT_POWER_ENABLE_N_OUT,
    input wire [3:0] PORT_POWER_ENABLE_N_OE_OUT
);
    logic seen;
    logic [2:0] stage, pola;
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (RST_IN);
    // mirror: load is staged, the first done applies it
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            seen <= 1'b0;
            stage <= 3'h7;
            pola <= 3'h7;
        end else begin
            if (CFG_LOAD_IN && !seen) begin
                stage <= CFG_POLARITY_IN;
            end
            if (CFG_DONE_IN && !seen) begin
                seen <= 1'b1;
                pola <= stage;
            end
        end
    end
    amber_reset_a: assert property ($fell(RST_IN)
        |-> PORT_AMBER_N_OUT == 4'hF) else $error("amber not idle");
    green_reset_a: assert property ($fell(RST_IN)
        |-> PORT_GREEN_N_OUT == 4'hF) else $error("green not idle");
    power_float_a: assert property ($fell(RST_IN)
        |-> PORT_POWER_ENABLE_N_OE_OUT == 4'h0) else $error("power driven");
    oe_wait_cfg_a: assert property (
        PORT_POWER_ENABLE_N_OE_OUT != 4'h0 |-> seen)
        else $error("power driven before config");
    oe_after_cfg_a: assert property ($rose(seen)
        |=> PORT_POWER_ENABLE_N_OE_OUT == 4'hF) else $error("no drive");
    pin_polarity_a: assert property ($rose(seen) |=>
        PORT_AMBER_N_OUT == {4{pola[0]}} && PORT_GREEN_N_OUT ==
        {4{pola[0]}} && PORT_POWER_ENABLE_N_OUT == {4{pola[2]}})
        else $error("idle level wrong");
    oc_cuts_power_a: assert property (
        (PORT_OVERCURRENT_N_IN[1] != pola[1]) [*4] |=>
        PORT_POWER_ENABLE_N_OUT[1] == $past(pola[2]))
        else $error("power kept on overcurrent");
    cover property ($rose(seen));
    cover property ($rose(IRQ_OUT));
    cover property ((PORT_OVERCURRENT_N_IN[1] != pola[1]) [*4]);
endmodule
bind hppi_top hppi_chk i_chk (.SYS_CLK_IN, .RST_IN, .CFG_LOAD_IN,
    .CFG_POLARITY_IN, .CFG_DONE_IN, .IRQ_OUT, .PORT_OVERCURRENT_N_IN,
    .PORT_AMBER_N_OUT, .PORT_GREEN_N_OUT, .PORT_POWER_ENABLE_N_OUT,
    .PORT_POWER_ENABLE_N_OE_OUT);
`default_nettype wire

/* verification/hppi_top_tb_top.sv */
// bench for the port pin block: apb tasks and pin checks
`timescale 1ns/100ps
`default_nettype none
`include "hppi_defs.vh"
module hppi_top_tb_top;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, load = 0;
    logic done = 0, idle_hi = 1, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, q;
    logic [2:0] pol = 3'h7;
    logic [1:0] fault = 2'h0;
    wire [31:0] prdata;
    wire pready, pslverr, irq;
    wire [3:0] oc_n, amber, green, pwrn, oe, pwire;
    int fails = 0, checked = 0;
    always #12.5 clk = ~clk;
    hppi_top i_dut (.SYS_CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel),
        .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .IRQ_OUT(irq), .CFG_LOAD_IN(load),
        .CFG_POLARITY_IN(pol), .CFG_DONE_IN(done),
        .PORT_OVERCURRENT_N_IN(oc_n), .PORT_AMBER_N_OUT(amber),
        .PORT_GREEN_N_OUT(green), .PORT_POWER_ENABLE_N_OUT(pwrn),
        .PORT_POWER_ENABLE_N_OE_OUT(oe));
    hppi_board i_board (.clk_in(clk), .idle_hi_in(idle_hi),
        .fault_in(fault), .pwr_n_in(pwrn), .pwr_oe_in(oe),
        .oc_n_out(oc_n), .pwr_wire_out(pwire));
    task end_sim;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task pins(input logic [3:0] a, input logic [3:0] g, input logic [3:0] p);
        chk({amber, green, pwrn}, {a, g, p});
    endtask
    // settle past the edge so registered outputs have landed
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task run(input logic [2:0] p);
        rst <= 1'b1;
        done <= 1'b0;
        idle_hi <= p[1];
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        pins(4'hF, 4'hF, 4'hF);
        chk(oe, 4'h0);
        @(posedge clk);
        load <= 1'b1;
        pol <= p;
        @(posedge clk);
        load <= 1'b0;
        done <= 1'b1;
        tick(1);
        chk(oe, 4'h0);
        tick(2);
        pins({4{p[0]}}, {4{p[0]}}, {4{p[2]}});
        chk(oe, 4'hF);
        // before config the new idle level looks like overcurrent
        apb(`HPPI_ADDR_STATUS, 1'b0, 32'h0);
        chk(q, p[1] ? 32'h0 : 32'hF);
        apb(`HPPI_ADDR_POLARITY, 1'b1, 32'h0);
        apb(`HPPI_ADDR_POLARITY, 1'b0, 32'h0);
        chk(q, {29'h0, p});
        apb(`HPPI_ADDR_MASK, 1'b1, 32'h3);
        apb(`HPPI_ADDR_CTRL, 1'b1, 32'h0000_0A53);
        tick(1);
        pins({4{p[0]}} ^ 4'h5, {4{p[0]}} ^ 4'hA, {4{p[2]}} ^ 4'h3);
        chk(pwire, {4{p[2]}} ^ 4'h3);
        chk(irq, 1'b0);
        @(posedge clk);
        fault <= 2'b10;
        tick(4);
        chk(irq, 1'b1);
        chk(pwrn, {4{p[2]}} ^ 4'h1);
        apb(`HPPI_ADDR_STATE, 1'b0, 32'h0);
        chk(q, 32'h0000_01F2);
        apb(`HPPI_ADDR_STATUS, 1'b0, 32'h0);
        chk(q, 32'h2);
        fault <= 2'b00;
        tick(1);
        chk(irq, 1'b0);
        // disabling port 3 drops its drive and forces its pins idle
        apb(`HPPI_ADDR_ENABLE, 1'b1, 32'h7);
        tick(1);
        chk(oe, 4'h7);
        pins({4{p[0]}} ^ 4'h5, {4{p[0]}} ^ 4'h2, {4{p[2]}} ^ 4'h1);
        apb(12'h020, 1'b0, 32'h0);
        chk(err, 1'b1);
        chk(q, 32'h0);
    endtask
    initial begin
        run(3'h7);
        run(3'h0);
        end_sim;
    end
    initial begin
        #100000;
        fails++;
        end_sim;
    end
endmodule
`default_nettype wire
